/* dvf_regs.svh */
// constants of the serial converter front end
`ifndef DVF_REGS_SVH
`define DVF_REGS_SVH
`define DVF_ADDR_PREFIX 5'h13
`define DVF_HS_CODE 5'h01
`define DVF_DIR_WRITE 1'h0
`define DVF_LAST_BIT 4'h7
`define DVF_ACK_BIT 4'h8
`define DVF_CTRL_SEL_HI 2
`define DVF_CTRL_SEL_LO 1
`define DVF_CTRL_LOAD_HI 5
`define DVF_CTRL_LOAD_LO 4
`define DVF_LSB_CODE_HI 7
`define DVF_LSB_CODE_LO 4
`define DVF_CLK_PERIOD_NS 4
`define DVF_FS_SPIKE_NS 50
`define DVF_HS_SPIKE_NS 10
`define DVF_FS_SPIKE_CYC (`DVF_FS_SPIKE_NS / `DVF_CLK_PERIOD_NS)
`define DVF_HS_SPIKE_CYC (`DVF_HS_SPIKE_NS / `DVF_CLK_PERIOD_NS)
`endif

/* dvf_pkg.sv */
// types of the serial converter front end
package dvf_pkg;
  typedef enum logic [2:0] {
    DVF_IDLE, DVF_ADDR, DVF_CTRL, DVF_MSB, DVF_LSB, DVF_SKIP
  } dvf_phase_t;
  typedef logic [7:0] dvf_byte_t;
  typedef logic [3:0] dvf_cnt_t;
endpackage

/* dvf_link_if.sv */
// signals between the bus-clock engine and the system-clock core
interface dvf_link_if;
  import dvf_pkg::*;
  logic sda_pin;
  logic [1:0] addr_sel;
  logic drive_low;
  logic hs_tgl;
  logic upd_tgl;
  logic start_seen;
  dvf_byte_t ctrl_byte;
  dvf_byte_t msb_byte;
  dvf_byte_t lsb_byte;
  modport eng (
    input sda_pin, addr_sel, start_seen,
    output drive_low, hs_tgl, upd_tgl, ctrl_byte, msb_byte, lsb_byte
  );
  modport core (
    output sda_pin, addr_sel, start_seen,
    input drive_low, hs_tgl, upd_tgl, ctrl_byte, msb_byte, lsb_byte
  );
endinterface

/* dvf_bit_engine.sv */
// byte framing, address match and acknowledge on the bus clock
`include "dvf_regs.svh"
module dvf_bit_engine
  import dvf_pkg::*;
(
  input wire logic scl, // bus clock from the master
  input wire logic rst, // asynchronous reset, high
  dvf_link_if.eng lk // toward the system-clock core
);
  logic bit_reg;
  dvf_cnt_t cnt_reg;
  dvf_byte_t shift_reg;
  dvf_phase_t phase_reg;
  logic ack_reg;
  logic pend_reg;
  logic hs_tgl_reg;
  logic upd_tgl_reg;
  dvf_byte_t ctrl_reg;
  dvf_byte_t msb_reg;
  dvf_byte_t lsb_reg;
  logic start_w;
  logic active_w;
  logic last_bit_w;
  logic ack_end_w;
  logic match_w;
  logic data_w;
  dvf_byte_t byte_w;

  // high at rise, low at fall: sda fell while scl was high; a start
  // after a stop has no scl rise in between, so the core flags it
  assign start_w = (bit_reg & ~lk.sda_pin) | lk.start_seen;
  assign active_w = (phase_reg != DVF_IDLE) & ~start_w;
  assign last_bit_w = active_w & (cnt_reg == `DVF_LAST_BIT);
  assign ack_end_w = active_w & (cnt_reg == `DVF_ACK_BIT);
  assign byte_w = {shift_reg[6:0], bit_reg};
  // general call and 10-bit headers never carry this prefix
  assign match_w = byte_w[7:1] == {`DVF_ADDR_PREFIX, lk.addr_sel};
  assign data_w = (phase_reg == DVF_CTRL) | (phase_reg == DVF_MSB) |
                  (phase_reg == DVF_LSB);

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      bit_reg <= 1'h1;
    end else begin
      bit_reg <= lk.sda_pin;
    end
  end

  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (start_w) begin
      cnt_reg <= 4'h0;
    end else if (ack_end_w) begin
      cnt_reg <= 4'h0;
    end else if (active_w) begin
      cnt_reg <= cnt_reg + 4'h1;
      shift_reg <= byte_w;
    end
  end

  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      phase_reg <= DVF_IDLE;
    end else if (start_w) begin
      phase_reg <= DVF_ADDR;
    end else if (last_bit_w) begin
      unique case (phase_reg)
        DVF_ADDR: phase_reg <= (match_w && byte_w[0] == `DVF_DIR_WRITE) ?
                               DVF_CTRL : DVF_SKIP;
        DVF_CTRL: phase_reg <= DVF_MSB;
        DVF_MSB: phase_reg <= DVF_LSB;
        DVF_LSB: phase_reg <= DVF_MSB;
        DVF_IDLE, DVF_SKIP: phase_reg <= phase_reg;
      endcase
    end
  end

  // ack is raised after the eighth fall, so sda moves only with scl low
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'h0;
    end else if (start_w || ack_end_w) begin
      ack_reg <= 1'h0;
    end else if (last_bit_w) begin
      ack_reg <= ((phase_reg == DVF_ADDR) & match_w) | data_w;
    end
  end

  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      ctrl_reg <= 8'h00;
      msb_reg <= 8'h00;
      lsb_reg <= 8'h00;
    end else if (last_bit_w) begin
      if (phase_reg == DVF_CTRL) begin
        ctrl_reg <= byte_w;
      end
      if (phase_reg == DVF_MSB) begin
        msb_reg <= byte_w;
      end
      if (phase_reg == DVF_LSB) begin
        lsb_reg <= byte_w;
      end
    end
  end

  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'h0;
      upd_tgl_reg <= 1'h0;
    end else if (start_w) begin
      pend_reg <= 1'h0;
    end else if (last_bit_w && phase_reg == DVF_LSB) begin
      pend_reg <= 1'h1;
    end else if (ack_end_w && pend_reg) begin
      pend_reg <= 1'h0;
      upd_tgl_reg <= ~upd_tgl_reg;
    end
  end

  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      hs_tgl_reg <= 1'h0;
    end else if (last_bit_w && phase_reg == DVF_ADDR &&
                 byte_w[7:3] == `DVF_HS_CODE) begin
      hs_tgl_reg <= ~hs_tgl_reg;
    end
  end

  assign lk.drive_low = ack_reg;
  assign lk.hs_tgl = hs_tgl_reg;
  assign lk.upd_tgl = upd_tgl_reg;
  assign lk.ctrl_byte = ctrl_reg;
  assign lk.msb_byte = msb_reg;
  assign lk.lsb_byte = lsb_reg;
endmodule

/* dvf_dac_front.sv */
// two-wire slave front end delivering codes to four converter channels
`include "dvf_regs.svh"
module dvf_dac_front
  import dvf_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int CODE_W = 12
) (
  input wire logic clk, // system clock
  input wire logic rst, // asynchronous reset, high
  input wire logic scl, // bus clock pin, link clock
  input wire logic sda_in, // data pin level
  output logic sda_out, // data pin drive value
  output logic sda_oe_n, // data pin enable, low drives
  output logic scl_out, // clock pin drive value
  output logic scl_oe_n, // clock pin enable, never low
  input wire logic addr_select_hi, // device select strap, high
  input wire logic addr_select_lo, // device select strap, low
  output logic [NUM_CH-1:0][CODE_W-1:0] dac_code, // channel codes
  output logic dac_load, // one-cycle pulse per update
  output logic [$clog2(NUM_CH)-1:0] dac_chan, // channel of update
  output logic [1:0] dac_mode, // load mode from control byte
  output logic hs_mode, // high speed settings active
  output logic bus_busy // between start and stop
);
  localparam int CH_W = $clog2(NUM_CH);

  dvf_link_if lk ();

  dvf_bit_engine u_engine (
    .scl(scl),
    .rst(rst),
    .lk(lk)
  );

  logic sda_s1_reg, sda_s2_reg, scl_s1_reg, scl_s2_reg;
  logic sda_f_reg, scl_f_reg, sda_prev_reg;
  dvf_cnt_t sda_cnt_reg, scl_cnt_reg;
  logic [1:0] as_s1_reg, as_s2_reg, addr_sel_reg;
  logic strap_done_reg;
  logic hs_s1_reg, hs_s2_reg, hs_s3_reg;
  logic upd_s1_reg, upd_s2_reg, upd_s3_reg;
  logic drv_s1_reg, drv_s2_reg;
  logic bus_active_reg, hs_mode_reg, dac_load_reg;
  logic start_seen_reg;
  logic sda_oe_n_reg, sda_out_reg, scl_out_reg, scl_oe_n_reg;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_code_reg;
  logic [CH_W-1:0] dac_chan_reg;
  logic [1:0] dac_mode_reg;
  logic start_det, stop_det, hs_edge, upd_edge;
  logic [CODE_W-1:0] new_code_w;
  logic [CH_W-1:0] new_chan_w;

  // spike width the filters reject, shorter once in high speed
  function automatic dvf_cnt_t dvf_spike_len(input logic hs);
    return hs ? 4'(`DVF_HS_SPIKE_CYC) : 4'(`DVF_FS_SPIKE_CYC);
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_s1_reg <= 1'h1;
      sda_s2_reg <= 1'h1;
      scl_s1_reg <= 1'h1;
      scl_s2_reg <= 1'h1;
    end else begin
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      scl_s1_reg <= scl;
      scl_s2_reg <= scl_s1_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_f_reg <= 1'h1;
      sda_cnt_reg <= 4'h0;
    end else if (sda_s2_reg == sda_f_reg) begin
      sda_cnt_reg <= 4'h0;
    end else if (sda_cnt_reg >= dvf_spike_len(hs_mode_reg)) begin
      sda_f_reg <= sda_s2_reg;
      sda_cnt_reg <= 4'h0;
    end else begin
      sda_cnt_reg <= sda_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_f_reg <= 1'h1;
      scl_cnt_reg <= 4'h0;
    end else if (scl_s2_reg == scl_f_reg) begin
      scl_cnt_reg <= 4'h0;
    end else if (scl_cnt_reg >= dvf_spike_len(hs_mode_reg)) begin
      scl_f_reg <= scl_s2_reg;
      scl_cnt_reg <= 4'h0;
    end else begin
      scl_cnt_reg <= scl_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_prev_reg <= 1'h1;
    end else begin
      sda_prev_reg <= sda_f_reg;
    end
  end

  assign start_det = scl_f_reg & sda_prev_reg & ~sda_f_reg;
  assign stop_det = scl_f_reg & ~sda_prev_reg & sda_f_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_active_reg <= 1'h0;
    end else if (start_det) begin
      bus_active_reg <= 1'h1;
    end else if (stop_det) begin
      bus_active_reg <= 1'h0;
    end
  end

  // held from start until filtered scl falls, so the engine reads it
  // steady at its next fall; needs a start hold above the filter delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_seen_reg <= 1'h0;
    end else if (start_det) begin
      start_seen_reg <= 1'h1;
    end else if (!scl_f_reg) begin
      start_seen_reg <= 1'h0;
    end
  end

  // straps settle before traffic; caught once after reset release
  // no reset here: the pair fills during reset, so capture sees the pins
  always_ff @(posedge clk) begin
    as_s1_reg <= {addr_select_hi, addr_select_lo};
    as_s2_reg <= as_s1_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_sel_reg <= 2'h0;
      strap_done_reg <= 1'h0;
    end else if (!strap_done_reg) begin
      addr_sel_reg <= as_s2_reg;
      strap_done_reg <= 1'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_s1_reg <= 1'h0;
      hs_s2_reg <= 1'h0;
      hs_s3_reg <= 1'h0;
      upd_s1_reg <= 1'h0;
      upd_s2_reg <= 1'h0;
      upd_s3_reg <= 1'h0;
      drv_s1_reg <= 1'h0;
      drv_s2_reg <= 1'h0;
    end else begin
      hs_s1_reg <= lk.hs_tgl;
      hs_s2_reg <= hs_s1_reg;
      hs_s3_reg <= hs_s2_reg;
      upd_s1_reg <= lk.upd_tgl;
      upd_s2_reg <= upd_s1_reg;
      upd_s3_reg <= upd_s2_reg;
      drv_s1_reg <= lk.drive_low;
      drv_s2_reg <= drv_s1_reg;
    end
  end

  assign hs_edge = hs_s2_reg ^ hs_s3_reg;
  assign upd_edge = upd_s2_reg ^ upd_s3_reg;

  // entry wins over a stop in the same cycle so no master code is lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_mode_reg <= 1'h0;
    end else if (hs_edge) begin
      hs_mode_reg <= 1'h1;
    end else if (stop_det) begin
      hs_mode_reg <= 1'h0;
    end
  end

  // data bytes stay put in the engine for many scl periods after the toggle
  assign new_code_w = CODE_W'({lk.msb_byte,
    lk.lsb_byte[`DVF_LSB_CODE_HI:`DVF_LSB_CODE_LO]});
  assign new_chan_w =
    CH_W'(lk.ctrl_byte[`DVF_CTRL_SEL_HI:`DVF_CTRL_SEL_LO]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_code_reg <= '0;
      dac_chan_reg <= '0;
      dac_mode_reg <= 2'h0;
    end else if (upd_edge && bus_active_reg) begin
      dac_code_reg[new_chan_w] <= new_code_w;
      dac_chan_reg <= new_chan_w;
      dac_mode_reg <=
        lk.ctrl_byte[`DVF_CTRL_LOAD_HI:`DVF_CTRL_LOAD_LO];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_load_reg <= 1'h0;
    end else begin
      dac_load_reg <= upd_edge & bus_active_reg;
    end
  end

  // pins: only pull low, never drive high; scl is never stretched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_oe_n_reg <= 1'h1;
      sda_out_reg <= 1'h0;
      scl_oe_n_reg <= 1'h1;
      scl_out_reg <= 1'h0;
    end else begin
      sda_oe_n_reg <= ~(drv_s2_reg & bus_active_reg);
      sda_out_reg <= 1'h0;
      scl_oe_n_reg <= 1'h1;
      scl_out_reg <= 1'h0;
    end
  end

  assign lk.sda_pin = sda_in;
  assign lk.addr_sel = addr_sel_reg;
  assign lk.start_seen = start_seen_reg;
  assign sda_out = sda_out_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign scl_out = scl_out_reg;
  assign scl_oe_n = scl_oe_n_reg;
  assign dac_code = dac_code_reg;
  assign dac_load = dac_load_reg;
  assign dac_chan = dac_chan_reg;
  assign dac_mode = dac_mode_reg;
  assign hs_mode = hs_mode_reg;
  assign bus_busy = bus_active_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_busy: assert property (start_det |=> bus_active_reg)
    else $error("start did not mark the bus busy");
  a_stop_free: assert property (stop_det |=> !bus_active_reg)
    else $error("stop did not free the bus");
  a_free_silent: assert property (
    !bus_active_reg |=> sda_oe_n_reg && !dac_load_reg)
    else $error("activity while the bus is free");
  a_hs_entry: assert property (hs_edge |=> hs_mode_reg [*2])
    else $error("master code did not enter high speed");
  a_hs_exit: assert property (
    stop_det && !hs_edge |=> !hs_mode_reg)
    else $error("stop did not leave high speed");
  a_load_code: assert property (
    upd_edge && bus_active_reg |=> dac_load_reg &&
    dac_code_reg[dac_chan_reg] == $past(new_code_w))
    else $error("update did not load the channel code");
  a_load_pulse: assert property (
    dac_load_reg |=> !dac_load_reg)
    else $error("load pulse longer than one cycle");
  a_drive_scl_low: assert property (
    $changed(sda_oe_n_reg) && bus_active_reg && $past(bus_active_reg)
    |-> !scl_s2_reg)
    else $error("sda drive changed while scl high");
  a_scl_released: assert property (scl_oe_n_reg)
    else $error("scl was driven");
  a_strap_fixed: assert property (
    strap_done_reg && $past(strap_done_reg) |-> $stable(addr_sel_reg))
    else $error("address straps changed after capture");
  a_start_flag: assert property (start_det |=> start_seen_reg)
    else $error("start not flagged to the bus engine");
  a_start_clear: assert property (
    !scl_f_reg && !start_det |=> !start_seen_reg)
    else $error("start flag outlived the clock fall");

  c_hs_entry: cover property (hs_edge ##1 hs_mode_reg);
  c_update: cover property (dac_load_reg);
  c_ack: cover property (!sda_oe_n_reg);
  c_stop_hs: cover property (hs_mode_reg && stop_det);
endmodule

/* dvf_bus_master.sv */
// two-wire bus master model driving the converter front end
module dvf_bus_master (
  output logic scl, // bus clock, only the master drives it
  output logic sda_rel, // high releases the data wire
  input wire logic sda // resolved data wire
);
  timeunit 1ns;
  timeprecision 100ps;
  int half_ns = 80; // 160 ns link clock until high speed is entered
  initial begin
    scl = 1'b1; // idle bus rests high
    sda_rel = 1'b1;
  end
  // start, or a repeated start when scl is low
  task automatic start_cond();
    if (!scl) begin
      #(half_ns / 4) sda_rel = 1'b1;
      #(half_ns) scl = 1'b1;
      #80;
    end
    sda_rel = 1'b0;
    #160 scl = 1'b0;
  endtask
  // a high at either end of the high phase reads as high
  task automatic put_bit(input logic b, output logic seen);
    logic s1;
    scl = 1'b0;
    #(half_ns / 4) sda_rel = b; // data moves only while scl low
    #(half_ns * 3 / 4) scl = 1'b1;
    #5 s1 = sda;
    #(half_ns - 10) seen = s1 | sda;
    #5 scl = 1'b0;
  endtask
  // msb first, then the acknowledge slot
  task automatic send_byte(input logic [7:0] d, output logic [8:0] seen);
    for (int i = 7; i >= 0; i--) put_bit(d[i], seen[i + 1]);
    put_bit(1'b1, seen[0]);
  endtask
  task automatic stop_cond();
    scl = 1'b0;
    #(half_ns / 4) sda_rel = 1'b0;
    #(half_ns) scl = 1'b1;
    #160 sda_rel = 1'b1;
    #200;
  endtask
endmodule

/* test_dvf_dac_front.sv */
// self-checking bench of the two-wire converter front end
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module test_dvf_dac_front;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] ctrl; logic [11:0] code;} dvf_row_t;
  localparam logic [7:0] ADDR_W = 8'h9C; // straps high, low
  logic clk, rst, m_scl, m_rel, sda_out, sda_oe_n, scl_out, scl_oe_n;
  logic dac_load, hs_mode, bus_busy;
  logic [3:0][11:0] dac_code;
  logic [1:0] dac_chan, dac_mode;
  wire logic sda_w;
  wire logic scl_w;
  int mismatches = 0;
  int total_checks = 0;
  int load_cnt = 0;
  int n;
  logic [8:0] s;
  dvf_row_t rows [4] = '{'{8'h10, 12'hFFF}, '{8'h02, 12'h001},
    '{8'h24, 12'hABC}, '{8'h36, 12'h800}};
  logic [7:0] bad [4] = '{8'h9E, 8'h98, 8'h00, 8'hF0};
  // wire-and of all open-drain parties, pull-up when released
  assign sda_w = m_rel & (sda_oe_n | sda_out);
  assign scl_w = m_scl & (scl_oe_n | scl_out);
  dvf_bus_master u_dvf_bus_master (.scl(m_scl), .sda_rel(m_rel),
    .sda(sda_w));
  dvf_dac_front #(.NUM_CH(4), .CODE_W(12)) u_dvf_dac_front (.clk(clk),
    .rst(rst), .scl(scl_w), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .addr_select_hi(1'b1), .addr_select_lo(1'b0), .dac_code(dac_code),
    .dac_load(dac_load), .dac_chan(dac_chan), .dac_mode(dac_mode),
    .hs_mode(hs_mode), .bus_busy(bus_busy));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (dac_load === 1'b1) load_cnt++;
  task automatic wr(input logic [7:0] b, input logic ack);
    logic [8:0] r;
    u_dvf_bus_master.send_byte(b, r);
    `CHK(r[0], ~ack)
  endtask
  task automatic done(input string t);
    $display("test %s finished, %0d mismatches", t, mismatches);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #300_000;
    mismatches++;
    $display("watchdog expired");
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (8) @(posedge clk);
    `CHK(dac_code, '0)
    `CHK({sda_oe_n, scl_oe_n, hs_mode, bus_busy}, 4'b1100)
    `CHK({sda_out, scl_out}, 2'h0)
    done("reset");
    for (int i = 0; i < 4; i++) begin
      n = load_cnt;
      u_dvf_bus_master.start_cond();
      `CHK(bus_busy, 1'b1)
      wr(ADDR_W, 1'b1);
      wr(rows[i].ctrl, 1'b1);
      wr(rows[i].code[11:4], 1'b1);
      wr({rows[i].code[3:0], 4'h5}, 1'b1);
      #40;
      `CHK(load_cnt, n + 1)
      `CHK(dac_code[rows[i].ctrl[2:1]], rows[i].code)
      `CHK(dac_chan, rows[i].ctrl[2:1])
      `CHK(dac_mode, rows[i].ctrl[5:4])
      u_dvf_bus_master.stop_cond();
      `CHK(bus_busy, 1'b0)
    end
    done("rows");
    n = load_cnt;
    for (int i = 0; i < 4; i++) begin
      u_dvf_bus_master.start_cond();
      wr(bad[i], 1'b0);
      wr(8'h10, 1'b0);
      wr(8'h12, 1'b0);
      wr(8'h30, 1'b0);
      u_dvf_bus_master.stop_cond();
    end
    wr(ADDR_W, 1'b0);
    u_dvf_bus_master.start_cond();
    wr(ADDR_W, 1'b1);
    wr(8'h10, 1'b1);
    wr(8'h77, 1'b1);
    u_dvf_bus_master.start_cond();
    u_dvf_bus_master.stop_cond();
    `CHK(load_cnt, n)
    done("refused");
    u_dvf_bus_master.start_cond();
    wr(8'h0B, 1'b0);
    `CHK(hs_mode, 1'b1)
    u_dvf_bus_master.half_ns = 40;
    n = load_cnt;
    u_dvf_bus_master.start_cond();
    wr(ADDR_W, 1'b1);
    wr(8'h14, 1'b1);
    wr(8'h5A, 1'b1);
    wr(8'h65, 1'b1);
    wr(8'h0F, 1'b1);
    wr(8'hF0, 1'b1);
    #40;
    `CHK(load_cnt, n + 2)
    `CHK(dac_code[2], 12'h0FF)
    `CHK(hs_mode, 1'b1)
    u_dvf_bus_master.stop_cond();
    u_dvf_bus_master.half_ns = 80;
    `CHK(hs_mode, 1'b0)
    done("high_speed");
    u_dvf_bus_master.start_cond();
    wr(8'h9D, 1'b1);
    u_dvf_bus_master.send_byte(8'hFF, s);
    `CHK(s[8:1], 8'hFF)
    u_dvf_bus_master.stop_cond();
    done("read");
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    `CHK(dac_code, '0)
    done("second_reset");
    end_of_test();
  end
endmodule
